// file: design/tol_threshold.sv
// Thermal overload threshold, blocking and supervision logic with AHB-Lite registers
//
// Overview of operation
// - All four protection outputs come only from the thermal capacity input.
// - First alarm acts only when enabled; threshold default 40 %, 0.1 % steps.
// - Second alarm acts only when its own enable is on; default 40 %.
// - Restart inhibit acts only when enabled; default threshold 80 %.
// - Trip follows trip threshold (default 100 %) plus delay in 5 ms steps.
// - Blocking input is sampled at the start of each program cycle.
// - Pick-up without blocking raises start and runs the delay timing.
// - Pick-up with blocking raises blocked and nothing further.
// - Blocking during start clears start and releases like pick-up drop-out.
// - Report condition normal, alarms, inhibit, trip or blocked; normal drives no alarm, inhibit or trip.
// - Report behaviour mode only when per-function mode setting is allowed.
// - Light or no load when current is under 1 % of nominal.
// - Normal load when current exceeds neither the service factor in use nor twice nominal.
// - Overloading above pick-up below twice nominal; high overload above twice.
// - Invalid service factor is replaced by 1.0 and flagged while invalid.
// - Invalid ambient settings give correction 1.0 and an ambient fault flag.
// - Invalid nominal current setting gives 1.0 and a nominal fault flag.
// - Inconsistent ambient correction factors raise their own fault flag.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module tol_threshold #(
  parameter int PCYC_CYC = tol_pkg::PCYC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Thermal image side
  input wire logic [10:0] tcap_i,
  input wire logic [15:0] cur_i,
  input wire logic [15:0] kamb_i,
  // Blocking matrix
  input wire logic block_i,
  // Protection outputs
  output logic alarm1_o,
  output logic alarm2_o,
  output logic inhibit_o,
  output logic trip_o,
  output logic start_o,
  output logic blocked_o,
  // Indications
  output logic [2:0] cond_o,
  output logic [1:0] motor_o,
  output logic [2:0] beh_o,
  output logic beh_valid_o,
  output logic fault_sf_o,
  output logic fault_amb_o,
  output logic fault_inom_o,
  output logic fault_k_o,
  output logic [15:0] sf_used_o,
  output logic [15:0] inom_used_o,
  output logic [15:0] kamb_used_o
);

  // Program cycle divider must fit its counter
  if (PCYC_CYC < 2 || PCYC_CYC > 524288) begin : g_chk
    $error("PCYC_CYC out of range");
  end
  // Delay step equals one program cycle
  if (tol_pkg::DLY_RES_CYC != tol_pkg::PCYC_CYC) begin : g_chk2
    $error("delay step differs from program cycle");
  end

  tol_pkg::tol_st_s s;
  tol_pkg::tol_st_s n;
  logic off;
  logic blk_eff;
  logic pick;

  // Combinational next state
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.ready = 1'b1;
    off = s.ctrl.allow && s.ctrl.mode == tol_pkg::B_OFF;
    blk_eff = s.blk;
    pick = 1'b0;
    // Program cycle divider
    // Every protection decision waits for the tick, so all protection outputs move together
    if (s.div == 19'(PCYC_CYC - 1)) begin
      n.div = '0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 19'h00001;
    end
    // Data phase write, applied before the read so back-to-back reads see it
    // Narrow fields keep their low bits; the unused upper bits are dropped
    if (s.wpend) begin
      n.wpend = 1'b0;
      if (s.waddr == tol_pkg::A_CTRL) begin
        n.ctrl = hwdata;
        n.ctrl.rsv = '0;
      end else if (s.waddr == tol_pkg::A_LVL1) begin
        n.lvl1 = hwdata[10:0];
      end else if (s.waddr == tol_pkg::A_LVL2) begin
        n.lvl2 = hwdata[10:0];
      end else if (s.waddr == tol_pkg::A_LVLI) begin
        n.lvli = hwdata[10:0];
      end else if (s.waddr == tol_pkg::A_LVLT) begin
        n.lvlt = hwdata[10:0];
      end else if (s.waddr == tol_pkg::A_DLY) begin
        n.dly = hwdata[19:0];
      end else if (s.waddr == tol_pkg::A_SF) begin
        n.sf = hwdata[15:0];
      end else if (s.waddr == tol_pkg::A_AMBT) begin
        n.ambt = hwdata;
      end else if (s.waddr == tol_pkg::A_AMBK) begin
        n.ambk = hwdata;
      end else if (s.waddr == tol_pkg::A_INOM) begin
        n.inom = hwdata[15:0];
      end
    end
    // Address phase: capture writes, answer reads next cycle
    // Read data is loaded here so it stands for the whole data phase
    if (hsel && hready && htrans[1]) begin
      n.wpend = hwrite && hsize == 3'h2;
      n.waddr = {haddr[7:2], 2'h0};
      n.rdata = '0;
      if (!hwrite) begin
        if (haddr[7:0] == tol_pkg::A_CTRL) begin
          n.rdata = n.ctrl;
        end else if (haddr[7:0] == tol_pkg::A_LVL1) begin
          n.rdata = {21'h00000, n.lvl1};
        end else if (haddr[7:0] == tol_pkg::A_LVL2) begin
          n.rdata = {21'h00000, n.lvl2};
        end else if (haddr[7:0] == tol_pkg::A_LVLI) begin
          n.rdata = {21'h00000, n.lvli};
        end else if (haddr[7:0] == tol_pkg::A_LVLT) begin
          n.rdata = {21'h00000, n.lvlt};
        end else if (haddr[7:0] == tol_pkg::A_DLY) begin
          n.rdata = {12'h000, n.dly};
        end else if (haddr[7:0] == tol_pkg::A_SF) begin
          n.rdata = {16'h0000, n.sf};
        end else if (haddr[7:0] == tol_pkg::A_AMBT) begin
          n.rdata = n.ambt;
        end else if (haddr[7:0] == tol_pkg::A_AMBK) begin
          n.rdata = n.ambk;
        end else if (haddr[7:0] == tol_pkg::A_INOM) begin
          n.rdata = {16'h0000, n.inom};
        end else if (haddr[7:0] == tol_pkg::A_STAT) begin
          n.rdata = s.st;
        end else if (haddr[7:0] == tol_pkg::A_USED) begin
          n.rdata = {s.inom_used, s.sf_used};
        end else if (haddr[7:0] == tol_pkg::A_KAMB) begin
          n.rdata = {16'h0000, s.k_used};
        end
      end
    end
    // Setting supervision, shown only while the fault stands
    // A bad service factor, ambient or nominal setting never reaches the thermal logic: 1.0 stands in while it is bad
    n.st.f_sf = s.sf == '0 || s.sf > tol_pkg::FAC_MAX;
    n.st.f_amb = s.ambt[15:0] <= s.ambt[31:16];
    n.st.f_inom = s.inom == '0;
    n.st.f_k = s.ambk[15:0] == '0 || s.ambk[31:16] == '0 ||
               s.ambk[15:0] > tol_pkg::FAC_MAX || s.ambk[31:16] > tol_pkg::FAC_MAX;
    n.sf_used = n.st.f_sf ? tol_pkg::ONE : s.sf;
    n.k_used = n.st.f_amb ? tol_pkg::ONE : kamb_i;
    n.inom_used = n.st.f_inom ? tol_pkg::ONE : s.inom;
    // Behaviour mode indication
    n.st.allow = s.ctrl.allow;
    n.st.beh = s.ctrl.allow ? s.ctrl.mode : tol_pkg::B_ON;
    // Motor load status from measured current
    // The pick-up limit is the factor in use, so a bad factor cannot mask an overload
    if (cur_i < tol_pkg::CUR_LIGHT) begin
      n.st.motor = tol_pkg::M_LIGHT;
    end else if (cur_i > tol_pkg::CUR_HIGH) begin
      n.st.motor = tol_pkg::M_HIGH;
    end else if (cur_i > s.sf_used) begin
      n.st.motor = tol_pkg::M_OVER;
    end else begin
      n.st.motor = tol_pkg::M_NORMAL;
    end
    // Blocking is latched once per program cycle; keeps it early enough
    // One sample per cycle keeps a short glitch on the line from splitting a decision
    if (s.div == '0) begin
      n.blk = block_i || (s.ctrl.allow && (s.ctrl.mode == tol_pkg::B_BLK ||
              s.ctrl.mode == tol_pkg::B_TBLK));
    end
    // Program cycle evaluation of thresholds from thermal capacity only
    // The delay count saturates so a long delay cannot wrap and trip early
    if (s.tick) begin
      pick = tcap_i >= s.lvlt && !off;
      n.st.al1 = s.ctrl.en1 && !off && tcap_i >= s.lvl1;
      n.st.al2 = s.ctrl.en2 && !off && tcap_i >= s.lvl2;
      n.st.inh = s.ctrl.en_inh && !off && tcap_i >= s.lvli;
      if (pick && !blk_eff) begin
        n.st.start = 1'b1;
        n.st.blocked = 1'b0;
        n.st.trip = s.cnt >= s.dly;
        if (s.cnt != 20'hFFFFF) begin
          n.cnt = s.cnt + 20'h00001;
        end
      end else begin
        // Blocked or dropped pick-up releases at once; there is no release delay
        n.st.blocked = pick;
        n.st.start = 1'b0;
        n.st.trip = 1'b0;
        n.cnt = '0;
      end
    end
    // Operating condition, highest level first
    // Blocked ranks just below trip so the reason for a missing start is visible
    if (n.st.trip) begin
      n.st.cond = tol_pkg::C_TRIP;
    end else if (n.st.blocked) begin
      n.st.cond = tol_pkg::C_BLK;
    end else if (n.st.inh) begin
      n.st.cond = tol_pkg::C_INH;
    end else if (n.st.al2) begin
      n.st.cond = tol_pkg::C_AL2;
    end else if (n.st.al1) begin
      n.st.cond = tol_pkg::C_AL1;
    end else begin
      n.st.cond = tol_pkg::C_NORMAL;
    end
  end

  // State register
  // Settings leave reset at their defaults, with every output quiet
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl.mode <= tol_pkg::B_ON;
      s.lvl1 <= tol_pkg::LVL1_RST;
      s.lvl2 <= tol_pkg::LVL2_RST;
      s.lvli <= tol_pkg::LVLI_RST;
      s.lvlt <= tol_pkg::LVLT_RST;
      s.sf <= tol_pkg::ONE;
      s.ambt <= {16'h0000, tol_pkg::AMBT_MAX_RST};
      s.ambk <= {tol_pkg::ONE, tol_pkg::ONE};
      s.inom <= tol_pkg::ONE;
      s.ready <= 1'b1;
      s.st.cond <= tol_pkg::C_NORMAL;
      s.st.motor <= tol_pkg::M_LIGHT;
      s.st.beh <= tol_pkg::B_ON;
      s.sf_used <= tol_pkg::ONE;
      s.inom_used <= tol_pkg::ONE;
      s.k_used <= tol_pkg::ONE;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign alarm1_o = s.st.al1;
  assign alarm2_o = s.st.al2;
  assign inhibit_o = s.st.inh;
  assign trip_o = s.st.trip;
  assign start_o = s.st.start;
  assign blocked_o = s.st.blocked;
  assign cond_o = s.st.cond;
  assign motor_o = s.st.motor;
  assign beh_o = s.st.beh;
  assign beh_valid_o = s.st.allow;
  assign fault_sf_o = s.st.f_sf;
  assign fault_amb_o = s.st.f_amb;
  assign fault_inom_o = s.st.f_inom;
  assign fault_k_o = s.st.f_k;
  assign sf_used_o = s.sf_used;
  assign inom_used_o = s.inom_used;
  assign kamb_used_o = s.k_used;

  // Checks on the protection behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  al1_off_a: assert property (s.tick && !s.ctrl.en1 |=> !alarm1_o)
    else $error("alarm 1 set while disabled");
  al1_lvl_a: assert property (s.tick && s.ctrl.en1 && !off && tcap_i >= s.lvl1 |=> alarm1_o)
    else $error("alarm 1 missed at threshold");
  al2_low_a: assert property (s.tick && tcap_i < s.lvl2 |=> !alarm2_o)
    else $error("alarm 2 set below threshold");
  inh_lvl_a: assert property (s.tick && s.ctrl.en_inh && !off && tcap_i >= s.lvli |=> inhibit_o)
    else $error("inhibit missed at threshold");
  trip_zero_a: assert property (s.tick && s.dly == '0 && !s.blk && !off && tcap_i >= s.lvlt
    |=> trip_o && start_o)
    else $error("zero delay trip missed");
  trip_hold_a: assert property ($rose(trip_o) |-> start_o && $past(s.tick) && $past(s.cnt) >= s.dly)
    else $error("trip before delay");
  blk_pick_a: assert property (s.tick && s.blk && !off && tcap_i >= s.lvlt
    |=> blocked_o && !start_o && !trip_o)
    else $error("blocked pick-up processed");
  blk_samp_a: assert property (s.div == '0 && block_i |=> s.blk)
    else $error("blocking not sampled");
  cond_norm_a: assert property (cond_o == tol_pkg::C_NORMAL |-> !alarm1_o && !alarm2_o && !inhibit_o && !trip_o)
    else $error("outputs active in normal condition");
  cond_prio_a: assert property (inhibit_o && !trip_o && !blocked_o |-> cond_o == tol_pkg::C_INH)
    else $error("condition priority wrong");
  motor_lt_a: assert property (cur_i < tol_pkg::CUR_LIGHT |=> motor_o == tol_pkg::M_LIGHT)
    else $error("light load not shown");
  sf_sub_a: assert property (s.sf == '0 |=> fault_sf_o && sf_used_o == tol_pkg::ONE)
    else $error("service factor not substituted");

  // Start, release and blocked pick-up
  start_free_a: assert property (s.tick && !s.blk && !off && tcap_i >= s.lvlt
    |=> start_o && !blocked_o)
    else $error("free pick-up gave no start");
  blk_drop_a: assert property (s.tick && s.blk |=> !start_o && !trip_o)
    else $error("start kept under blocking");
  pick_drop_a: assert property (s.tick && tcap_i < s.lvlt |=> !start_o && !trip_o && !blocked_o)
    else $error("start kept after drop-out");
  trip_start_a: assert property (trip_o |-> start_o)
    else $error("trip without start");
  al2_lvl_a: assert property (s.tick && s.ctrl.en2 && !off && tcap_i >= s.lvl2 |=> alarm2_o)
    else $error("alarm 2 missed at threshold");
  al2_off_a: assert property (s.tick && !s.ctrl.en2 |=> !alarm2_o)
    else $error("alarm 2 set while disabled");
  inh_off_a: assert property (s.tick && !s.ctrl.en_inh |=> !inhibit_o)
    else $error("inhibit set while disabled");
  tick_once_a: assert property (s.tick |=> !s.tick)
    else $error("program tick longer than one cycle");
  blk_hold_a: assert property (s.div != '0 |=> s.blk == $past(s.blk))
    else $error("blocking sampled mid cycle");

  // Mode, condition and behaviour indications
  off_quiet_a: assert property (s.tick && off
    |=> !alarm1_o && !alarm2_o && !inhibit_o && !trip_o && !start_o && !blocked_o)
    else $error("outputs active in mode off");
  cond_blk_a: assert property (blocked_o && !trip_o |-> cond_o == tol_pkg::C_BLK)
    else $error("blocked condition not shown");
  cond_trip_a: assert property (trip_o |-> cond_o == tol_pkg::C_TRIP)
    else $error("trip condition not shown");
  beh_hide_a: assert property (!s.ctrl.allow |=> !beh_valid_o && beh_o == tol_pkg::B_ON)
    else $error("behaviour shown while not allowed");

  // Motor status and setting substitution
  motor_hi_a: assert property (cur_i > tol_pkg::CUR_HIGH |=> motor_o == tol_pkg::M_HIGH)
    else $error("high overload not shown");
  motor_nrm_a: assert property (cur_i >= tol_pkg::CUR_LIGHT && cur_i <= s.sf_used && cur_i <= tol_pkg::CUR_HIGH
    |=> motor_o == tol_pkg::M_NORMAL)
    else $error("normal load not shown");
  amb_sub_a: assert property (s.ambt[15:0] <= s.ambt[31:16] |=> fault_amb_o && kamb_used_o == tol_pkg::ONE)
    else $error("ambient correction not substituted");
  amb_use_a: assert property (s.ambt[15:0] > s.ambt[31:16]
    |=> !fault_amb_o && kamb_used_o == $past(kamb_i))
    else $error("ambient correction not passed on");
  inom_sub_a: assert property (s.inom == '0 |=> fault_inom_o && inom_used_o == tol_pkg::ONE)
    else $error("nominal current not substituted");
  k_flag_a: assert property (s.ambk[15:0] == '0 |=> fault_k_o)
    else $error("ambient factor fault not flagged");
  sf_ok_a: assert property (s.sf == tol_pkg::ONE |=> !fault_sf_o && sf_used_o == tol_pkg::ONE)
    else $error("service factor fault shown while valid");

  // Main scenarios
  trip_c: cover property (s.tick && s.dly != '0 ##1 (!trip_o) [*3] ##1 $rose(trip_o));
  block_c: cover property ($rose(blocked_o));
  restart_c: cover property (start_o ##1 (s.blk && s.tick) ##1 !start_o);
  all_c: cover property (alarm1_o && alarm2_o && inhibit_o && trip_o);
  fault_c: cover property ($rose(fault_sf_o));

endmodule
`default_nettype wire

// file: design/tol_pkg.sv
// Constants, register map and types of the thermal overload threshold logic
`default_nettype none
package tol_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LVL1 = 8'h04;
  localparam logic [7:0] A_LVL2 = 8'h08;
  localparam logic [7:0] A_LVLI = 8'h0C;
  localparam logic [7:0] A_LVLT = 8'h10;
  localparam logic [7:0] A_DLY = 8'h14;
  localparam logic [7:0] A_SF = 8'h18;
  localparam logic [7:0] A_AMBT = 8'h1C;
  localparam logic [7:0] A_AMBK = 8'h20;
  localparam logic [7:0] A_INOM = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_USED = 8'h2C;
  localparam logic [7:0] A_KAMB = 8'h30;
  // Threshold reset values in 0.1 % steps
  localparam logic [10:0] LVL1_RST = 11'h190;
  localparam logic [10:0] LVL2_RST = 11'h190;
  localparam logic [10:0] LVLI_RST = 11'h320;
  localparam logic [10:0] LVLT_RST = 11'h3E8;
  // Factors and currents in 0.01 steps
  localparam logic [15:0] ONE = 16'h0064;
  localparam logic [15:0] FAC_MAX = 16'h01F4;
  localparam logic [15:0] CUR_LIGHT = 16'h0001;
  localparam logic [15:0] CUR_HIGH = 16'h00C8;
  localparam logic [15:0] AMBT_MAX_RST = 16'h002D;
  // Program cycle and trip delay step, in ms
  localparam int PCYC_MS = 5;
  localparam int DLY_RES_MS = 5;
  localparam int BLK_LEAD_MS = 5;
  localparam int CLK_KHZ = 100000;
  localparam int PCYC_CYC = PCYC_MS * CLK_KHZ;
  localparam int DLY_RES_CYC = DLY_RES_MS * CLK_KHZ;
  // Operating condition, motor load status, behaviour mode
  typedef enum logic [2:0] {C_NORMAL, C_AL1, C_AL2, C_INH, C_TRIP, C_BLK} tol_cond_e;
  typedef enum logic [1:0] {M_LIGHT, M_NORMAL, M_OVER, M_HIGH} tol_motor_e;
  typedef enum logic [2:0] {B_ON, B_BLK, B_TEST, B_TBLK, B_OFF} tol_beh_e;
  // Control register layout
  typedef struct packed {
    logic [24:0] rsv;
    tol_beh_e mode;
    logic allow;
    logic en_inh;
    logic en2;
    logic en1;
  } tol_ctrl_s;
  // Status register layout
  typedef struct packed {
    logic [12:0] rsv;
    logic allow;
    tol_beh_e beh;
    logic f_k;
    logic f_inom;
    logic f_amb;
    logic f_sf;
    tol_motor_e motor;
    tol_cond_e cond;
    logic blocked;
    logic start;
    logic trip;
    logic inh;
    logic al2;
    logic al1;
  } tol_stat_s;
  // Complete module state
  typedef struct packed {
    tol_ctrl_s ctrl;
    logic [10:0] lvl1;
    logic [10:0] lvl2;
    logic [10:0] lvli;
    logic [10:0] lvlt;
    logic [19:0] dly;
    logic [15:0] sf;
    logic [31:0] ambt;
    logic [31:0] ambk;
    logic [15:0] inom;
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic ready;
    logic [18:0] div;
    logic tick;
    logic blk;
    logic [19:0] cnt;
    tol_stat_s st;
    logic [15:0] sf_used;
    logic [15:0] inom_used;
    logic [15:0] k_used;
  } tol_st_s;
endpackage
`default_nettype wire

// file: testbench/tol_io_model.sv
// Far-side model: blocking matrix source and output I/O receiver
`default_nettype none
module tol_io_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench command and trip output
  input wire logic blk_req,
  input wire logic trip_o,
  // Blocking line and trip count
  output logic block_i,
  output int trips
);
  timeunit 1ns;
  timeprecision 1ns;
  logic trip_q;
  // Blocking follows the request one edge later, well ahead of any delay expiry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_i <= 1'b0;
      trip_q <= 1'b0;
      trips <= 0;
    end else begin
      block_i <= blk_req;
      trip_q <= trip_o;
      if (trip_o && !trip_q) trips <= trips + 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench of the thermal overload threshold logic
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 8;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, blk_req, block_i;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, motor;
  logic [2:0] hsize, cond, beh;
  logic [10:0] tcap;
  logic [15:0] cur, kamb, sfu, inu, ku;
  logic al1, al2, inh, trip, start, blkd, bv, fsf, famb, finom, fk;
  int failures, checks, trips;
  // Design under test with a short program cycle
  tol_threshold #(.PCYC_CYC(P)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tcap_i(tcap), .cur_i(cur),
    .kamb_i(kamb), .block_i(block_i), .alarm1_o(al1), .alarm2_o(al2), .inhibit_o(inh),
    .trip_o(trip), .start_o(start), .blocked_o(blkd), .cond_o(cond), .motor_o(motor),
    .beh_o(beh), .beh_valid_o(bv), .fault_sf_o(fsf), .fault_amb_o(famb), .fault_inom_o(finom),
    .fault_k_o(fk), .sf_used_o(sfu), .inom_used_o(inu), .kamb_used_o(ku));
  // Far side
  tol_io_model partner (.clk(clk), .reset_n(reset_n), .blk_req(blk_req), .trip_o(trip),
    .block_i(block_i), .trips(trips));
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // Let two program cycles pass and settle
  task automatic drv(input logic [10:0] t, input logic b);
    @(posedge clk);
    tcap <= t;
    blk_req <= b;
    repeat (2 * P + 3) @(posedge clk);
    #1;
  endtask
  // Register reset values, unmapped and read-only places
  task automatic t_regs();
    logic [7:0] a [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    logic [31:0] e [10] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8, 32'h0, 32'h64, 32'h2D,
      32'h00640064, 32'h64};
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("reset value", e[i], d);
    end
    bus(1'b0, 8'h34, 32'h0);
    chk("unmapped", 32'h0, d);
    bus(1'b1, 8'h2C, 32'hFFFFFFFF);
    bus(1'b0, 8'h2C, 32'h0);
    chk("used", 32'h00640064, d);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hready", 32'h1, {31'h0, hreadyout});
    drv(11'h3E7, 1'b0);
    chk("all off", 32'h0, {al1, al2, inh, trip, blkd, cond});
    $display("t_regs done");
  endtask
  // Alarm and inhibit thresholds, enables and priority
  task automatic t_alarm();
    drv(11'h000, 1'b0);
    bus(1'b1, tol_pkg::A_CTRL, 32'h1);
    drv(11'h190, 1'b0);
    chk("alarm1", 32'h1, {31'h0, al1});
    chk("alarm2 off", 32'h0, {31'h0, al2});
    chk("cond al1", 32'h1, {29'h0, cond});
    drv(11'h18F, 1'b0);
    chk("alarm1 drop", 32'h0, {31'h0, al1});
    bus(1'b1, tol_pkg::A_CTRL, 32'h7);
    drv(11'h320, 1'b0);
    chk("al1 al2 inh trip", 32'hE, {28'h0, al1, al2, inh, trip});
    chk("cond inh", 32'h3, {29'h0, cond});
    $display("t_alarm done");
  endtask
  // Trip after two program cycles of delay
  task automatic t_trip();
    bus(1'b1, tol_pkg::A_DLY, 32'h2);
    @(posedge clk);
    tcap <= 11'h3E8;
    for (int i = 0; i < 3 * P && start !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("start", 32'h1, {31'h0, start});
    chk("trip early", 32'h0, {31'h0, trip});
    repeat (P) @(posedge clk);
    #1;
    chk("trip one cycle", 32'h0, {31'h0, trip});
    repeat (P) @(posedge clk);
    #1;
    chk("trip", 32'h1, {31'h0, trip});
    chk("cond trip", 32'h4, {29'h0, cond});
    bus(1'b0, tol_pkg::A_STAT, 32'h0);
    chk("status", 32'h11F, d);
    drv(11'h000, 1'b0);
    chk("trip release", 32'h0, {31'h0, trip});
    chk("trips seen", 32'h1, trips);
    $display("t_trip done");
  endtask
  // Blocked pick-up, then blocking during start
  task automatic t_block();
    bus(1'b1, tol_pkg::A_DLY, 32'h64);
    drv(11'h000, 1'b1);
    drv(11'h3E8, 1'b1);
    chk("blocked", 32'h1, {30'h0, start, blkd});
    chk("cond blk", 32'h5, {29'h0, cond});
    drv(11'h3E8, 1'b0);
    chk("start free", 32'h2, {30'h0, start, blkd});
    drv(11'h3E8, 1'b1);
    chk("start cleared", 32'h0, {30'h0, start, trip});
    drv(11'h000, 1'b0);
    $display("t_block done");
  endtask
  // Motor load status from current
  task automatic t_motor();
    logic [15:0] c [4] = '{16'h0000, 16'h0032, 16'h0096, 16'h00FA};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cur <= c[i];
      repeat (3) @(posedge clk);
      #1;
      chk("motor", i, {30'h0, motor});
    end
    $display("t_motor done");
  endtask
  // Setting faults and used values
  task automatic t_fault();
    logic [7:0] a [4] = '{tol_pkg::A_SF, tol_pkg::A_AMBT, tol_pkg::A_INOM, tol_pkg::A_AMBK};
    logic [31:0] bad [4] = '{32'h0, 32'h002D002D, 32'h0, 32'h00640000};
    logic [31:0] ok [4] = '{32'h64, 32'h2D, 32'h64, 32'h00640064};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, a[i], bad[i]);
      repeat (4) @(posedge clk);
      #1;
      chk("fault flags", 32'h8 >> i, {28'h0, fsf, famb, finom, fk});
      if (i < 3) chk("used", 32'h64, i == 0 ? sfu : (i == 1 ? ku : inu));
      bus(1'b1, a[i], ok[i]);
      repeat (4) @(posedge clk);
      #1;
      chk("fault clear", 32'h0, {28'h0, fsf, famb, finom, fk});
    end
    chk("k used", 32'h50, ku);
    $display("t_fault done");
  endtask
  // Behaviour mode indication and mode off
  task automatic t_mode();
    bus(1'b1, tol_pkg::A_CTRL, 32'h28);
    repeat (3) @(posedge clk);
    #1;
    chk("beh test", 32'hA, {28'h0, bv, beh});
    bus(1'b1, tol_pkg::A_CTRL, 32'h18);
    drv(11'h3E8, 1'b0);
    chk("mode blocked", 32'h1, {30'h0, start, blkd});
    bus(1'b1, tol_pkg::A_CTRL, 32'h4F);
    drv(11'h3E8, 1'b0);
    chk("mode off", 32'h0, {27'h0, al1, al2, inh, trip, start});
    bus(1'b1, tol_pkg::A_CTRL, 32'h0);
    drv(11'h000, 1'b0);
    chk("beh hidden", 32'h0, {28'h0, bv, beh});
    $display("t_mode done");
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #100000;
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    {hsel, hwrite, blk_req, haddr, hwdata, htrans, hsize, tcap, cur} = '0;
    kamb = 16'h0050;
    failures = 0;
    checks = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_alarm();
    t_trip();
    t_block();
    t_motor();
    t_fault();
    t_mode();
    summarize();
  end
endmodule
`default_nettype wire
